// ---- src/capture_defs.svh ----
// Summary of operation
// - Event copies 16-bit timer into result
// - Mode selects falling, rising, 4th, 16th
// - Each capture sets the interrupt flag
// - New capture overwrites unread result
// - Detector watches pin level regardless direction
// - Mode change may set flag spuriously
// - Prescaler cleared on reset, off, non-capture
// - Prescaler switch keeps count unchanged
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH

// ****************************************************************
// Register map and field layout.
// ****************************************************************
`define ADDR_W           4
`define DATA_W           8
`define OFF_CONTROL      4'h0
`define OFF_RESULT_LOW   4'h1
`define OFF_RESULT_HIGH  4'h2
`define OFF_FLAG         4'h3
`define OFF_ENABLE       4'h4
`define MODE_W           4
`define RST_MODE         4'h0
`define RST_BYTE         8'h00
`define PRESC_W          4
`define PRESC_CLR        4'h0
`define PRESC_LAST_4     4'h3
`define PRESC_LAST_16    4'hf
`define MODE_FALL        4'h4
`define MODE_RISE        4'h5
`define MODE_RISE4       4'h6
`define MODE_RISE16      4'h7

`endif

// ---- src/capture_pkg.sv ----
`include "capture_defs.svh"

package capture_pkg;

    // ****************************************************************
    // Types shared by the capture unit.
    // ****************************************************************
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic               wr;
        logic               rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        EVT_FALL   = 2'b00,
        EVT_RISE   = 2'b01,
        EVT_RISE4  = 2'b10,
        EVT_RISE16 = 2'b11
    } evt_kind_t;

endpackage : capture_pkg

// ---- src/timer_input_capture.sv ----
`timescale 1ns/1ps
`include "capture_defs.svh"

module timer_input_capture
    import capture_pkg::*;
(
    input  wire logic               sys_clk,       // System clock, 100 MHz.
    input  wire logic               nrst,          // Asynchronous reset, active low.
    input  wire reg_req_t           req,           // Register access request.
    output logic [`DATA_W-1:0]      rdata,         // Read data, cycle after read strobe.
    input  wire logic               capture_input_pin, // Pin level, from outside the domain.
    input  wire logic [15:0]        timer_count,   // Companion timer count, same clock.
    output logic                    irq            // Level interrupt.
);

    // ****************************************************************
    // Decoding helpers.
    // ****************************************************************
    function automatic logic is_capture(input logic [`MODE_W-1:0] m);
        is_capture = (m == `MODE_FALL) || (m == `MODE_RISE) || (m == `MODE_RISE4) || (m == `MODE_RISE16);
    endfunction : is_capture

    function automatic evt_kind_t kind_of(input logic [`MODE_W-1:0] m);
        kind_of = evt_kind_t'(m[1:0]);
    endfunction : kind_of

    logic [`MODE_W-1:0] capture_mode_select_r;
    logic [15:0]        result_r;
    logic               capture_irq_flag_r;
    logic               capture_irq_enable_r;
    logic [2:0]         pin_sync_r;
    logic               pin_stable_r;
    logic [`PRESC_W-1:0] presc_r;
    logic               rise;
    logic               fall;
    logic               capture;
    logic               mode_change;
    logic               capture_seen_r;
    logic               wr_ctrl;

    // ****************************************************************
    // Pin synchroniser and edge detection.
    // ****************************************************************

    // Three stages; a change counts once the last two agree. The pin is
    // watched whatever its direction, so a port write can trigger.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_sync_r   <= 3'h0;
            pin_stable_r <= 1'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], capture_input_pin};
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                pin_stable_r <= pin_sync_r[2];
            end
        end
    end

    assign rise = (pin_sync_r[1] == pin_sync_r[2]) && pin_sync_r[2] && !pin_stable_r;
    assign fall = (pin_sync_r[1] == pin_sync_r[2]) && !pin_sync_r[2] && pin_stable_r;
    assign wr_ctrl = req.wr && (req.addr == `OFF_CONTROL);
    assign mode_change = wr_ctrl && (req.wdata[`MODE_W-1:0] != capture_mode_select_r);

    // ****************************************************************
    // Prescaler and event qualification.
    // ****************************************************************

    // One capture per qualified edge after prescaling.
    always_comb begin
        capture = 1'b0;
        if (is_capture(capture_mode_select_r)) begin
            case (kind_of(capture_mode_select_r))
                EVT_FALL:   capture = fall;
                EVT_RISE:   capture = rise;
                EVT_RISE4:  capture = rise && (presc_r[1:0] == 2'(`PRESC_LAST_4));
                EVT_RISE16: capture = rise && (presc_r == `PRESC_LAST_16);
                default:    capture = 1'b0;
            endcase
        end
    end

    // The counter is not cleared on a direct switch between capture
    // settings, so a stale count can fire early; clearing the control
    // register first avoids it.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            presc_r <= `PRESC_CLR;
        end else if (!is_capture(capture_mode_select_r)) begin
            presc_r <= `PRESC_CLR;
        end else if (rise) begin
            presc_r <= presc_r + 4'h1;
        end
    end

    // ****************************************************************
    // Capture result and control register.
    // ****************************************************************

    // Every capture overwrites the result, read or not.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            result_r <= 16'h0000;
        end else if (capture) begin
            result_r <= timer_count;
        end
    end

    // Writing the control register sets the mode; zero turns the unit off.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            capture_mode_select_r <= `RST_MODE;
            capture_irq_enable_r  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                capture_mode_select_r <= req.wdata[`MODE_W-1:0];
            end
            if (req.wr && (req.addr == `OFF_ENABLE)) begin
                capture_irq_enable_r <= req.wdata[0];
            end
        end
    end

    // ****************************************************************
    // Interrupt flag and output.
    // ****************************************************************

    // Set wins over a write-one clear. A mode change sets it spuriously,
    // which is why software masks it while reconfiguring.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            capture_irq_flag_r <= 1'b0;
        end else if (capture || mode_change) begin
            capture_irq_flag_r <= 1'b1;
        end else if (req.wr && (req.addr == `OFF_FLAG) && req.wdata[0]) begin
            capture_irq_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= capture_irq_flag_r && capture_irq_enable_r;
        end
    end

    // ****************************************************************
    // Register read port.
    // ****************************************************************

    // Unmapped addresses read as zero.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= `RST_BYTE;
        end else if (req.rd) begin
            case (req.addr)
                `OFF_CONTROL:     rdata <= {4'h0, capture_mode_select_r};
                `OFF_RESULT_LOW:  rdata <= result_r[7:0];
                `OFF_RESULT_HIGH: rdata <= result_r[15:8];
                `OFF_FLAG:        rdata <= {7'h00, capture_irq_flag_r};
                `OFF_ENABLE:      rdata <= {7'h00, capture_irq_enable_r};
                default:          rdata <= `RST_BYTE;
            endcase
        end else begin
            rdata <= `RST_BYTE;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            capture_seen_r <= 1'b0;
        end else begin
            capture_seen_r <= capture;
        end
    end

    result_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        capture |=> (result_r == $past(timer_count)))
        else $error("Result did not take the timer count.");

    flag_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        capture |=> capture_irq_flag_r)
        else $error("Capture did not set the flag.");

    flag_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (capture_irq_flag_r && !(req.wr && req.addr == `OFF_FLAG)) |=> capture_irq_flag_r)
        else $error("Flag cleared without software.");

    presc_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !is_capture(capture_mode_select_r) |=> (presc_r == `PRESC_CLR))
        else $error("Prescaler not cleared outside capture.");

    mode_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode_change && !rise && is_capture(capture_mode_select_r)) |=> (presc_r == $past(presc_r)))
        else $error("Prescaler changed on a mode switch.");

    single_capture_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        capture_seen_r |-> !capture)
        else $error("Two captures from one edge.");

    fall_mode_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        capture && capture_mode_select_r == `MODE_FALL |-> !pin_sync_r[2])
        else $error("Falling mode captured on a high pin.");

    spurious_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_change |=> capture_irq_flag_r)
        else $error("Mode change did not set the flag.");

    overwrite_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (capture && capture_irq_flag_r) |=> (result_r == $past(timer_count)))
        else $error("Unread result was not overwritten.");

    sync_path_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        rise |-> ($past(capture_input_pin, 3) && $past(capture_input_pin, 2)))
        else $error("Edge taken before pin settled.");

endmodule : timer_input_capture

// ---- test/event_source.sv ----
`timescale 1ns/1ps

// ********
// Far side: event pin source and companion timer.
// ********
module event_source (
    input  wire logic        sys_clk,           // System clock.
    input  wire logic        nrst,              // Reset, active low.
    input  wire logic        pin_level,         // Level the bench asks for.
    input  wire logic        hold,              // Freeze the timer at load_val.
    input  wire logic [15:0] load_val,          // Count shown while frozen.
    output logic             capture_input_pin, // Pin as seen by the unit.
    output logic [15:0]      timer_count        // Companion timer count.
);
    // The pin behaves as an input driven from outside, moving after an edge.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            capture_input_pin <= 1'b0;
        else
            capture_input_pin <= pin_level;
    end

    // Synchronous timer; freezing it makes the captured value predictable.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            timer_count <= 16'h0000;
        else if (hold)
            timer_count <= load_val;
        else
            timer_count <= timer_count + 16'h0001;
    end
endmodule : event_source

// ---- test/tb_timer_input_capture.sv ----
`timescale 1ns/1ps
`include "capture_defs.svh"

module tb_timer_input_capture
    import capture_pkg::*;
;
    typedef struct {logic [3:0] mode; int pulses; logic flag;} row_t;

    logic        sys_clk, nrst, pin_level, hold, pin, irq;
    reg_req_t    req;
    logic [7:0]  rdata;
    logic [15:0] load_val, timer_count, last;
    int          err_total, checked, cycles;
    row_t        rows [8] = '{'{`MODE_FALL, 1, 1'b1}, '{`MODE_RISE, 1, 1'b1},
                              '{`MODE_RISE4, 3, 1'b0}, '{`MODE_RISE4, 4, 1'b1},
                              '{`MODE_RISE16, 15, 1'b0}, '{`MODE_RISE16, 16, 1'b1},
                              '{4'h0, 2, 1'b0}, '{4'h8, 1, 1'b0}};

    timer_input_capture dut_u (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata),
                               .capture_input_pin(pin), .timer_count(timer_count), .irq(irq));
    event_source src_u (.sys_clk(sys_clk), .nrst(nrst), .pin_level(pin_level), .hold(hold),
                        .load_val(load_val), .capture_input_pin(pin), .timer_count(timer_count));

    // ********
    // Helpers.
    // ********
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // An idle edge after each strobe keeps a strobe from being set twice at once.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge sys_clk);
        req.wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 chk(name, {8'h00, rdata}, {8'h00, exp});
        @(posedge sys_clk);
    endtask : rd

    task automatic pulse(input int n);
        repeat (n) begin
            pin_level <= 1'b1;
            repeat (4) @(posedge sys_clk);
            pin_level <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
    endtask : pulse

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // Clock and hang guard; the whole run needs under a thousand cycles.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end

    // ********
    // Main sequence.
    // ********
    initial begin
        nrst = 1'b0;
        req = '0;
        pin_level = 1'b0;
        hold = 1'b1;
        load_val = 16'h0000;
        last = 16'h0000;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int a = 0; a < 6; a++) rd(4'(a), 8'h00, "reset");
        wr(4'h5, 8'hff);
        rd(4'h5, 8'h00, "unmapped");
        // Table: off first so the edge count restarts, then clear the spurious flag.
        foreach (rows[i]) begin
            wr(`OFF_CONTROL, 8'h00);
            wr(`OFF_CONTROL, {4'h0, rows[i].mode});
            wr(`OFF_FLAG, 8'h01);
            load_val <= 16'h1234 + 16'(i * 16'h0101);
            if (rows[i].flag)
                last = 16'h1234 + 16'(i * 16'h0101);
            pulse(rows[i].pulses);
            rd(`OFF_FLAG, {7'h00, rows[i].flag}, "flag");
            rd(`OFF_RESULT_LOW, last[7:0], "res_low");
            rd(`OFF_RESULT_HIGH, last[15:8], "res_high");
        end
        // Mode change raises the flag; it stays until software clears it.
        wr(`OFF_ENABLE, 8'h01);
        wr(`OFF_CONTROL, {4'h0, `MODE_RISE});
        repeat (20) @(posedge sys_clk);
        rd(`OFF_FLAG, 8'h01, "spurious");
        chk("irq_on", {15'h0, irq}, 16'h0001);
        wr(`OFF_ENABLE, 8'h00);
        @(posedge sys_clk);
        chk("irq_masked", {15'h0, irq}, 16'h0000);
        wr(`OFF_ENABLE, 8'h01);
        wr(`OFF_FLAG, 8'h01);
        @(posedge sys_clk);
        chk("irq_clear", {15'h0, irq}, 16'h0000);
        // Direct switch keeps the edge count: 2 + 13 edges stop one short, the next is the 16th.
        wr(`OFF_CONTROL, 8'h00);
        wr(`OFF_CONTROL, {4'h0, `MODE_RISE4});
        pulse(2);
        wr(`OFF_CONTROL, {4'h0, `MODE_RISE16});
        wr(`OFF_FLAG, 8'h01);
        pulse(13);
        rd(`OFF_FLAG, 8'h00, "keep_short");
        pulse(1);
        rd(`OFF_FLAG, 8'h01, "keep_count");
        // A second capture before the result is read replaces it.
        wr(`OFF_CONTROL, {4'h0, `MODE_RISE});
        load_val <= 16'h5a01;
        pulse(1);
        load_val <= 16'ha502;
        pulse(1);
        rd(`OFF_RESULT_LOW, 8'h02, "over_low");
        rd(`OFF_RESULT_HIGH, 8'ha5, "over_high");
        // Reset in mid-run drops the interrupt and clears every register.
        wr(`OFF_ENABLE, 8'h01);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("irq_reset", {15'h0, irq}, 16'h0000);
        nrst <= 1'b1;
        for (int a = 0; a < 5; a++) rd(4'(a), 8'h00, "mid_reset");
        stop_test();
    end
endmodule : tb_timer_input_capture
